// *** verilog/vcdac_slave.sv ***
// two-wire slave front end and output code core of the voltage source
// What this block does
// [R01] serial clock is input only, never driven
// [R02] data line only pulled low, else released
// [R03] start is data falling while clock high
// [R04] stop is data rising while clock high
// [R05] address byte then acknowledge on ninth clock
// [R06] eight data bits plus one acknowledge bit
// [R07] data change during clock high is start/stop
// [R08] small variant address: six fixed, low pin
// [R09] large variant address: five fixed, two pins
// [R10] standard and fast work without entry sequence
// [R11] master sends code 00001xxx to enter high speed
// [R12] master code recognised, never acknowledged, no rw
// [R13] master code switches high speed mode on
// [R14] high speed persists over repeated starts
// [R15] stop leaves high speed mode
// [R16] general call address always acknowledged
// [R17] general call 06h acknowledged, full reset
// [R18] other general call data not acknowledged
// [R19] reset happens at power-up unprompted
// [R20] reset loads stored code, else midscale
// [R21] rw one reads, rw zero writes
// [R22] at most four nonvolatile programming cycles
// [R23] dac write two bytes, update after second
// [R24] read returns count thermometer and dac code
// [R25] single byte 001 reloads from memory or zero
// [R26] two bytes 010 program memory and dac
// [R27] unmatched address ignored until next start
module vcdac_slave
	import vcdac_pkg::*;
#(
	parameter bit PIN10 = 1'b0 // 1 selects the two-pin address variant
) (
	// core clock and power-up reset
	input wire logic clk_i,
	input wire logic reset_i,
	// link sampling clock
	input wire logic link_clk_i,
	// bus pins; clock is input only, data is open drain
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// address straps
	input wire logic addr_select_low_pin_i,
	input wire logic addr_select_high_pin_i,
	// core state
	output logic [9:0] dac_code_o,
	output logic [3:0] otp_status_o,
	output logic hs_mode_o
);
	// link bus states
	typedef enum logic [2:0] {
		VC_IDLE,
		VC_ADDR,
		VC_ACK,
		VC_RX,
		VC_TX,
		VC_TACK,
		VC_IGNORE
	} vcdac_state_t;

	// stored code when programmed, else the given default
	function automatic logic [9:0] reload_code(input logic prog, input logic [9:0] mem,
			input logic [9:0] dflt);
		reload_code = prog ? mem : dflt;
	endfunction

	logic lrst_meta_reg; // link reset release, first stage
	logic lrst; // link domain reset
	logic [3:0] pins_s; // synchronised {scl, sda, high pin, low pin}
	logic scl_d_reg; // previous sampled clock
	logic sda_d_reg; // previous sampled data
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [6:0] own_addr; // address from straps
	logic is_hs, is_gc_addr, own_match, byte_done;
	vcdac_state_t state_reg; // link state
	vcdac_state_t after_reg; // state after the acknowledge slot
	logic [3:0] bitcnt_reg; // bits of the current byte
	logic [7:0] shift_reg; // in or out byte
	logic gc_reg; // general call in progress
	logic idx_reg; // second byte of a transfer
	logic [1:0] hi_reg; // upper code bits from first byte
	logic otp_cmd_reg; // first byte asked for programming
	logic oe_n_reg; // data enable, low pulls the line low
	logic sda_o_reg; // open drain level, always low
	logic hs_reg; // high speed mode
	logic cmd_send_reg; // one-cycle command request
	vcdac_op_t cmd_op_reg; // command to the core
	logic [9:0] cmd_code_reg; // code carried with it
	logic [13:0] stat_l; // {thermometer, dac code} in link domain
	logic cmd_valid; // command arrived in core domain
	logic [11:0] cmd_data; // its word
	vcdac_op_t cmd_op;
	logic [9:0] dac_reg; // output code
	logic [9:0] otp_mem_reg; // nonvolatile code
	logic [3:0] otp_therm_reg; // programming count, thermometer coded

	// link reset: asserts with reset_i, releases on the link clock
	always_ff @(posedge link_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lrst_meta_reg <= 1'b1;
			lrst <= 1'b1;
		end else begin
			lrst_meta_reg <= 1'b0;
			lrst <= lrst_meta_reg;
		end
	end

	// pins and straps cross into the link clock
	vcdac_sync2 #(.W(4)) u_pins (
		.clk_i(link_clk_i),
		.reset_i(lrst),
		.d_i({scl_i, sda_i, addr_select_high_pin_i, addr_select_low_pin_i}),
		.q_o(pins_s)
	);

	// edge history for clock and data
	always_ff @(posedge link_clk_i or posedge lrst) begin
		if (lrst) begin
			scl_d_reg <= 1'b0;
			sda_d_reg <= 1'b0;
		end else begin
			scl_d_reg <= pins_s[3];
			sda_d_reg <= pins_s[2];
		end
	end

	// clock line is only observed, never driven [R01]
	assign scl_rise = pins_s[3] & ~scl_d_reg;
	assign scl_fall = ~pins_s[3] & scl_d_reg;
	// any data move with clock high is a condition, not a bit [R07]
	assign start_det = pins_s[3] & scl_d_reg & sda_d_reg & ~pins_s[2]; // [R03]
	assign stop_det = pins_s[3] & scl_d_reg & ~sda_d_reg & pins_s[2]; // [R04]

	// address decode; normal speed needs nothing special [R10]
	assign own_addr = PIN10 ? {ADDR10_FIXED, pins_s[1], pins_s[0]} // [R09]
		: {ADDR8_FIXED, pins_s[0]}; // [R08]
	assign is_hs = (shift_reg[7:3] == HS_CODE_TOP); // low three bits ignored [R12]
	assign is_gc_addr = (shift_reg == GC_ADDR);
	assign own_match = (shift_reg[7:1] == own_addr);
	// eight bits in and the clock has fallen: decide the ninth slot [R06]
	assign byte_done = scl_fall && (bitcnt_reg == BIT_LAST)
		&& (state_reg == VC_ADDR || state_reg == VC_RX);

	// bus state machine, shifting and acknowledge drive
	always_ff @(posedge link_clk_i or posedge lrst) begin
		if (lrst) begin
			state_reg <= VC_IDLE;
			after_reg <= VC_IDLE;
			bitcnt_reg <= BIT_RESET;
			shift_reg <= 8'h00;
			gc_reg <= 1'b0;
			idx_reg <= 1'b0;
			hi_reg <= 2'h0;
			otp_cmd_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			cmd_send_reg <= 1'b0;
			cmd_op_reg <= VCDAC_OP_DAC;
			cmd_code_reg <= 10'h000;
		end else begin
			cmd_send_reg <= 1'b0;
			if (start_det) begin
				// a start, repeated or not, abandons any half transfer [R23]
				state_reg <= VC_ADDR;
				bitcnt_reg <= BIT_RESET;
				gc_reg <= 1'b0;
				idx_reg <= 1'b0;
				oe_n_reg <= 1'b1;
			end else if (stop_det) begin
				// early stop also drops a pending update [R23]
				state_reg <= VC_IDLE;
				oe_n_reg <= 1'b1;
			end else begin
				case (state_reg)
					VC_ADDR, VC_RX: begin
						if (scl_rise && bitcnt_reg != BIT_LAST) begin
							shift_reg <= {shift_reg[6:0], pins_s[2]};
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end else if (byte_done) begin
							bitcnt_reg <= BIT_RESET;
							state_reg <= VC_ACK;
							if (state_reg == VC_ADDR) begin
								if (is_hs) begin
									// master code: no ack, wait for repeated start [R12]
									state_reg <= VC_IGNORE;
								end else if (is_gc_addr) begin
									gc_reg <= 1'b1;
									oe_n_reg <= 1'b0; // [R16]
									after_reg <= VC_RX;
								end else if (own_match) begin
									oe_n_reg <= 1'b0; // [R05]
									// last bit high selects a read [R21]
									after_reg <= shift_reg[0] ? VC_TX : VC_RX;
									// first read byte: count on top, code below [R24]
									shift_reg <= {stat_l[13:10], 2'h0, stat_l[9:8]};
								end else begin
									// not ours: stay off the bus [R27]
									state_reg <= VC_IGNORE;
								end
							end else if (gc_reg) begin
								if (shift_reg == GC_RESET_CODE) begin
									oe_n_reg <= 1'b0; // [R17]
									after_reg <= VC_IGNORE;
									cmd_send_reg <= 1'b1;
									cmd_op_reg <= VCDAC_OP_GCR;
								end else begin
									state_reg <= VC_IGNORE; // [R18]
								end
							end else if (!idx_reg && shift_reg[7:5] == CMD_TOP_ACQ) begin
								// one byte is the whole acquire command [R25]
								oe_n_reg <= 1'b0;
								after_reg <= VC_IGNORE;
								cmd_send_reg <= 1'b1;
								cmd_op_reg <= VCDAC_OP_ACQ;
							end else if (!idx_reg) begin
								// first byte: keep only the two code bits [R23]
								oe_n_reg <= 1'b0;
								idx_reg <= 1'b1;
								hi_reg <= shift_reg[1:0];
								otp_cmd_reg <= (shift_reg[7:5] == CMD_TOP_OTP); // [R26]
								after_reg <= VC_RX;
							end else begin
								// second byte completes the update [R23]
								oe_n_reg <= 1'b0;
								after_reg <= VC_IGNORE;
								cmd_send_reg <= 1'b1;
								cmd_op_reg <= otp_cmd_reg ? VCDAC_OP_OTP : VCDAC_OP_DAC; // [R26]
								cmd_code_reg <= {hi_reg, shift_reg};
							end
						end
					end
					VC_ACK: begin
						// ninth clock ends on its falling edge
						if (scl_fall) begin
							state_reg <= after_reg;
							oe_n_reg <= (after_reg == VC_TX) ? shift_reg[7] : 1'b1;
						end
					end
					VC_TX: begin
						// change data only while the clock is low [R07]
						if (scl_rise) begin
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end else if (scl_fall) begin
							if (bitcnt_reg == BIT_LAST) begin
								bitcnt_reg <= BIT_RESET;
								oe_n_reg <= 1'b1;
								state_reg <= VC_TACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b1};
								oe_n_reg <= shift_reg[6]; // a one is released, not driven [R02]
							end
						end
					end
					VC_TACK: begin
						// master ack after first byte brings the low byte [R24]
						if (scl_rise) begin
							after_reg <= (!pins_s[2] && !idx_reg) ? VC_TX : VC_IGNORE;
						end else if (scl_fall) begin
							state_reg <= after_reg;
							if (after_reg == VC_TX) begin
								idx_reg <= 1'b1;
								shift_reg <= stat_l[7:0];
								oe_n_reg <= stat_l[7];
							end
						end
					end
					VC_IDLE, VC_IGNORE: begin
						// released until the next start [R27]
						oe_n_reg <= 1'b1;
					end
					default: begin
						state_reg <= VC_IDLE;
						oe_n_reg <= 1'b1;
					end
				endcase
			end
		end
	end

	// high speed mode: on with master code, kept over restart, off at stop [R14]
	always_ff @(posedge link_clk_i or posedge lrst) begin
		if (lrst) begin
			hs_reg <= 1'b0;
		end else if (stop_det) begin
			hs_reg <= 1'b0; // [R15]
		end else if (cmd_send_reg && cmd_op_reg == VCDAC_OP_GCR) begin
			hs_reg <= 1'b0; // internal reset returns to normal speed [R17]
		end else if (byte_done && state_reg == VC_ADDR && is_hs) begin
			hs_reg <= 1'b1; // [R13]
		end
	end

	// open drain level is constant low; only the enable moves [R02]
	always_ff @(posedge link_clk_i or posedge lrst) begin
		if (lrst) begin
			sda_o_reg <= 1'b0;
		end else begin
			sda_o_reg <= 1'b0;
		end
	end

	// commands to the core; one per byte, far slower than the crossing
	vcdac_xfer #(.W(12)) u_cmd (
		.src_clk_i(link_clk_i),
		.src_reset_i(lrst),
		.src_send_i(cmd_send_reg),
		.src_data_i({cmd_op_reg, cmd_code_reg}),
		.src_busy_o(),
		.dst_clk_i(clk_i),
		.dst_reset_i(reset_i),
		.dst_valid_o(cmd_valid),
		.dst_data_o(cmd_data)
	);

	// core state refreshed into the link continuously
	vcdac_xfer #(.W(14)) u_stat (
		.src_clk_i(clk_i),
		.src_reset_i(reset_i),
		.src_send_i(1'b1),
		.src_data_i({otp_therm_reg, dac_reg}),
		.src_busy_o(),
		.dst_clk_i(link_clk_i),
		.dst_reset_i(lrst),
		.dst_valid_o(),
		.dst_data_o(stat_l)
	);

	assign cmd_op = vcdac_op_t'(cmd_data[11:10]);

	// output code: midscale or stored code after any reset
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			dac_reg <= DAC_MIDSCALE; // power-up memory is blank [R19]
		end else if (cmd_valid) begin
			case (cmd_op)
				VCDAC_OP_DAC: dac_reg <= cmd_data[9:0]; // [R23]
				VCDAC_OP_OTP: dac_reg <= cmd_data[9:0]; // [R26]
				VCDAC_OP_ACQ: dac_reg <= reload_code(otp_therm_reg[0], otp_mem_reg,
					DAC_ACQ_BLANK); // [R25]
				VCDAC_OP_GCR: dac_reg <= reload_code(otp_therm_reg[0], otp_mem_reg,
					DAC_MIDSCALE); // [R20]
				default: dac_reg <= dac_reg;
			endcase
		end
	end

	// nonvolatile store: survives general call, refuses a fifth write
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			otp_mem_reg <= OTP_MEM_RESET;
			otp_therm_reg <= OTP_THERM_RESET;
		end else if (cmd_valid && cmd_op == VCDAC_OP_OTP && !otp_therm_reg[3]) begin
			otp_mem_reg <= cmd_data[9:0]; // [R22]
			otp_therm_reg <= {otp_therm_reg[2:0], 1'b1};
		end
	end

	assign sda_o = sda_o_reg;
	assign sda_oe_n_o = oe_n_reg;
	assign hs_mode_o = hs_reg;
	assign dac_code_o = dac_reg;
	assign otp_status_o = otp_therm_reg;

	a_own_addr_ack: assert property (@(posedge link_clk_i) disable iff (lrst) // [R05]
		byte_done && state_reg == VC_ADDR && !is_hs && own_match && !start_det && !stop_det
		|=> !sda_oe_n_o && state_reg == VC_ACK)
		else $error("own address not acknowledged");
	a_hs_code_nack: assert property (@(posedge link_clk_i) disable iff (lrst) // [R12]
		byte_done && state_reg == VC_ADDR && is_hs && !start_det && !stop_det
		|=> sda_oe_n_o && hs_mode_o)
		else $error("master code acknowledged or mode not entered");
	a_hs_keep_rstart: assert property (@(posedge link_clk_i) disable iff (lrst) // [R14]
		hs_mode_o && start_det |=> hs_mode_o && state_reg == VC_ADDR)
		else $error("high speed lost at repeated start");
	a_hs_stop_exit: assert property (@(posedge link_clk_i) disable iff (lrst) // [R15]
		stop_det |=> !hs_mode_o && state_reg == VC_IDLE)
		else $error("stop did not leave high speed");
	a_gc_addr_ack: assert property (@(posedge link_clk_i) disable iff (lrst) // [R16]
		byte_done && state_reg == VC_ADDR && is_gc_addr && !start_det && !stop_det
		|=> !sda_oe_n_o ##1 gc_reg)
		else $error("general call not acknowledged");
	a_gc_bad_nack: assert property (@(posedge link_clk_i) disable iff (lrst) // [R18]
		byte_done && state_reg == VC_RX && gc_reg && shift_reg != GC_RESET_CODE
		&& !start_det && !stop_det |=> sda_oe_n_o && state_reg == VC_IGNORE)
		else $error("bad general call data acknowledged");
	a_ignore_release: assert property (@(posedge link_clk_i) disable iff (lrst) // [R27]
		state_reg == VC_IGNORE && $past(state_reg) == VC_IGNORE |-> sda_oe_n_o)
		else $error("data line driven while ignoring");
	a_tx_stable_high: assert property (@(posedge link_clk_i) disable iff (lrst) // [R07]
		state_reg == VC_TX && pins_s[3] && scl_d_reg && !start_det && !stop_det
		|=> $stable(sda_oe_n_o))
		else $error("data changed while clock high");
	a_gcr_reload: assert property (@(posedge clk_i) disable iff (reset_i) // [R17]
		cmd_valid && cmd_op == VCDAC_OP_GCR
		|=> dac_code_o == ($past(otp_therm_reg[0]) ? $past(otp_mem_reg) : DAC_MIDSCALE))
		else $error("general call reset loaded wrong code");
	a_otp_limit: assert property (@(posedge clk_i) disable iff (reset_i) // [R22]
		otp_therm_reg[3] |=> $stable(otp_mem_reg) && otp_therm_reg == 4'hF)
		else $error("memory written after four cycles");
endmodule // vcdac_slave

// *** pkg/vcdac_pkg.sv ***
// shared constants and types for the programmable voltage source serial slave
package vcdac_pkg;
	// power-up output code and the blank acquire code
	localparam logic [9:0] DAC_MIDSCALE = 10'h200;
	localparam logic [9:0] DAC_ACQ_BLANK = 10'h000;
	localparam logic [9:0] OTP_MEM_RESET = 10'h000;
	localparam logic [3:0] OTP_THERM_RESET = 4'h0;
	// fixed address bits for the two package variants
	localparam logic [5:0] ADDR8_FIXED = 6'h3B;
	localparam logic [4:0] ADDR10_FIXED = 5'h1D;
	// special bytes on the bus
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET_CODE = 8'h06;
	// command field in the top three bits of the first data byte
	localparam logic [2:0] CMD_TOP_ACQ = 3'h1;
	localparam logic [2:0] CMD_TOP_OTP = 3'h2;
	// bit count at which a byte is complete
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_RESET = 4'h0;
	// operations passed from the link to the core
	typedef enum logic [1:0] {
		VCDAC_OP_DAC,
		VCDAC_OP_OTP,
		VCDAC_OP_ACQ,
		VCDAC_OP_GCR
	} vcdac_op_t;
endpackage

// *** verilog/vcdac_sync2.sv ***
// two flip-flop level synchroniser
module vcdac_sync2 #(
	parameter int W = 1
) (
	// clock and reset of the receiving domain
	input wire logic clk_i,
	input wire logic reset_i,
	// level in and synchronised level out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg; // first stage, read only by the second
	logic [W-1:0] q_reg; // second stage

	// plain double register; reset to zero
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg <= meta_reg;
		end
	end

	assign q_o = q_reg;
endmodule // vcdac_sync2

// *** verilog/vcdac_xfer.sv ***
// toggle handshake carrying one word from one clock domain to another
module vcdac_xfer #(
	parameter int W = 8
) (
	// source domain
	input wire logic src_clk_i,
	input wire logic src_reset_i,
	input wire logic src_send_i,
	input wire logic [W-1:0] src_data_i,
	output logic src_busy_o,
	// destination domain
	input wire logic dst_clk_i,
	input wire logic dst_reset_i,
	output logic dst_valid_o,
	output logic [W-1:0] dst_data_o
);
	logic tog_reg; // flips once per word sent
	logic [W-1:0] hold_reg; // word held stable until acknowledged
	logic ack_s; // destination toggle seen back in source domain
	logic tog_s; // source toggle in destination domain
	logic seen_reg; // last toggle taken by the destination
	logic valid_reg; // one-cycle arrival pulse
	logic [W-1:0] data_reg; // captured word

	// source: a send while busy is dropped, so callers space their words
	always_ff @(posedge src_clk_i or posedge src_reset_i) begin
		if (src_reset_i) begin
			tog_reg <= 1'b0;
			hold_reg <= '0;
		end else if (src_send_i && !src_busy_o) begin
			tog_reg <= ~tog_reg;
			hold_reg <= src_data_i;
		end
	end

	assign src_busy_o = tog_reg ^ ack_s;

	// toggle into the destination
	vcdac_sync2 #(.W(1)) u_tog (
		.clk_i(dst_clk_i),
		.reset_i(dst_reset_i),
		.d_i(tog_reg),
		.q_o(tog_s)
	);

	// destination: hold_reg is stable by the time the toggle arrives
	always_ff @(posedge dst_clk_i or posedge dst_reset_i) begin
		if (dst_reset_i) begin
			seen_reg <= 1'b0;
			valid_reg <= 1'b0;
			data_reg <= '0;
		end else begin
			seen_reg <= tog_s;
			valid_reg <= tog_s ^ seen_reg;
			if (tog_s ^ seen_reg) begin
				data_reg <= hold_reg;
			end
		end
	end

	// acknowledge back into the source
	vcdac_sync2 #(.W(1)) u_ack (
		.clk_i(src_clk_i),
		.reset_i(src_reset_i),
		.d_i(seen_reg),
		.q_o(ack_s)
	);

	assign dst_valid_o = valid_reg;
	assign dst_data_o = data_reg;
endmodule // vcdac_xfer

// *** sim/vcdac_master_model.sv ***
// two-wire bus master model that drives the slave's clock and data lines
module vcdac_master_model (
	// bench clock paces every bus phase
	input wire logic clk_i,
	// resolved level of the data line
	input wire logic sda_i,
	// clock level and data pull-down request
	output logic scl_o,
	output logic sda_pull_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QTR = 5; // bench clocks per quarter bit, far above four link clocks

	// idle bus: both lines released to the pull-ups
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	// one quarter bit, always ending on a falling bench clock edge
	task automatic qwait();
		repeat (QTR) @(negedge clk_i);
	endtask

	// start or repeated start; data released first so a restart works too
	task automatic start_cond();
		sda_pull_o = 1'b0;
		qwait();
		scl_o = 1'b1;
		qwait();
		sda_pull_o = 1'b1;
		qwait();
		scl_o = 1'b0;
	endtask

	// stop: data rises while the clock is high
	task automatic stop_cond();
		qwait();
		sda_pull_o = 1'b1;
		qwait();
		scl_o = 1'b1;
		qwait();
		sda_pull_o = 1'b0;
		qwait();
	endtask

	// one bit; data only moves in the clock low phase, sampled mid high phase
	task automatic put_bit(input logic b, output logic seen);
		qwait();
		sda_pull_o = ~b;
		qwait();
		scl_o = 1'b1;
		qwait();
		seen = sda_i;
		qwait();
		scl_o = 1'b0;
	endtask

	// eight data bits msb first, then the acknowledge slot
	task automatic send_byte(input logic [7:0] data, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--) begin
			put_bit(data[i], seen);
		end
		put_bit(1'b1, seen);
		ack = ~seen;
	endtask

	// receive eight bits with the line released, then answer in the ninth
	task automatic recv_byte(input logic give_ack, output logic [7:0] data);
		logic seen;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, seen);
			data[i] = seen;
		end
		put_bit(~give_ack, seen);
	endtask
endmodule // vcdac_master_model

// *** sim/tb.sv ***
// self-checking bench for the two-wire slave of the voltage source
module tb;
	import vcdac_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0; // core clock
	logic link_clk = 1'b0; // link sampling clock
	logic reset_i = 1'b1; // power-up reset
	logic strap_low = 1'b0; // low address strap
	logic strap_high = 1'b0; // high address strap, read by the large variant only
	logic scl; // bus clock from the master
	logic pull; // master pulls data low
	wire logic sda; // resolved data wire
	logic sda_o;
	logic sda_oe_n;
	logic sda_oe2_n; // drive enable of the large-variant slave
	logic [9:0] dac_code2; // output code of the large-variant slave
	logic [9:0] dac_code;
	logic [3:0] otp_status;
	logic hs_mode;
	int num_errors = 0;
	int compares = 0;
	logic ack;
	logic [7:0] rd_hi;
	logic [7:0] rd_lo;
	logic [9:0] prog_code;
	logic [3:0] therm;

	// clocks; the link clock gets an odd offset so the phases never line up
	always #50 clk_i = ~clk_i;
	initial begin
		#13;
		forever #40 link_clk = ~link_clk;
	end
	// open-drain wire with pull-up: low if any of the three parties pulls
	assign sda = ~(pull | ~sda_oe_n | ~sda_oe2_n);

	vcdac_master_model i_m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	vcdac_slave #(.PIN10(1'b0)) i_dut (
		.clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
		.addr_select_low_pin_i(strap_low), .addr_select_high_pin_i(strap_high),
		.dac_code_o(dac_code), .otp_status_o(otp_status), .hs_mode_o(hs_mode)
	);
	// large variant on the same bus; its high strap low keeps the two addresses apart
	vcdac_slave #(.PIN10(1'b1)) i_dut2 (
		.clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe2_n),
		.addr_select_low_pin_i(strap_low), .addr_select_high_pin_i(strap_high),
		.dac_code_o(dac_code2), .otp_status_o(), .hs_mode_o()
	);

	// compare and count; four-state inequality so unknowns never match
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// send one byte and compare the acknowledge with the expected one
	task automatic send(input logic [7:0] b, input logic exp);
		i_m.send_byte(b, ack);
		check("acknowledge", {15'h0, ack}, {15'h0, exp});
	endtask

	// two-byte write to our own address, then stop and let the core settle
	task automatic dac_write(input logic [15:0] word);
		i_m.start_cond();
		send({ADDR8_FIXED, strap_low, 1'b0}, 1'b1);
		send(word[15:8], 1'b1);
		send(word[7:0], 1'b1);
		i_m.stop_cond();
		repeat (20) @(negedge clk_i);
	endtask

	// two-byte read, master acks the first byte only
	task automatic dac_read(input logic [15:0] exp);
		i_m.start_cond();
		send({ADDR8_FIXED, strap_low, 1'b1}, 1'b1);
		i_m.recv_byte(1'b1, rd_hi);
		i_m.recv_byte(1'b0, rd_lo);
		i_m.stop_cond();
		check("read word", {rd_hi, rd_lo}, exp);
	endtask

	// single-byte acquire command
	task automatic acquire();
		i_m.start_cond();
		send({ADDR8_FIXED, strap_low, 1'b0}, 1'b1);
		send({CMD_TOP_ACQ, 5'h1F}, 1'b1);
		i_m.stop_cond();
		repeat (20) @(negedge clk_i);
	endtask

	// general call address followed by one data byte
	task automatic gen_call(input logic [7:0] data, input logic exp);
		i_m.start_cond();
		send(GC_ADDR, 1'b1);
		send(data, exp);
		i_m.stop_cond();
		repeat (20) @(negedge clk_i);
	endtask

	// verdict and end of run
	task automatic end_of_test();
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog well past the expected length of the sequence
	initial begin
		repeat (60000) @(negedge clk_i);
		num_errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		repeat (16) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (40) @(negedge clk_i);
		check("power-up code", {6'h0, dac_code}, {6'h0, DAC_MIDSCALE});
		check("power-up status", {11'h0, otp_status, hs_mode}, 16'h0000);
		check("idle drive", {14'h0, sda_o, sda_oe_n}, 16'h0001);
		dac_read({6'h00, DAC_MIDSCALE});
		// both strap levels: only the matching address is answered
		for (int p = 0; p < 2; p++) begin
			strap_low = p[0];
			repeat (10) @(negedge clk_i);
			i_m.start_cond();
			send({ADDR8_FIXED, ~strap_low, 1'b0}, 1'b0);
			send(8'h02, 1'b0);
			i_m.start_cond();
			send({ADDR8_FIXED, strap_low, 1'b0}, 1'b1);
			i_m.stop_cond();
		end
		// only the large variant answers 11101yx; the small one keeps its code
		i_m.start_cond();
		send({ADDR10_FIXED, strap_high, strap_low, 1'b0}, 1'b1);
		send(8'h01, 1'b1);
		send(8'h23, 1'b1);
		i_m.stop_cond();
		repeat (20) @(negedge clk_i);
		check("large variant", {6'h0, dac_code2}, 16'h0123);
		check("small variant", {6'h0, dac_code}, {6'h0, DAC_MIDSCALE});
		dac_write(16'h02AB);
		check("dac write", {6'h0, dac_code}, 16'h02AB);
		// stop after the first byte must not update
		i_m.start_cond();
		send({ADDR8_FIXED, strap_low, 1'b0}, 1'b1);
		send(8'hFD, 1'b1);
		i_m.stop_cond();
		repeat (20) @(negedge clk_i);
		check("stop abort", {6'h0, dac_code}, 16'h02AB);
		// repeated start after the first byte must not update either
		i_m.start_cond();
		send({ADDR8_FIXED, strap_low, 1'b0}, 1'b1);
		send(8'h01, 1'b1);
		dac_read(16'h02AB);
		acquire();
		check("blank acquire", {6'h0, dac_code}, {6'h0, DAC_ACQ_BLANK});
		gen_call(8'h05, 1'b0);
		check("gc other", {6'h0, dac_code}, {6'h0, DAC_ACQ_BLANK});
		gen_call(GC_RESET_CODE, 1'b1);
		check("gc reset", {6'h0, dac_code}, {6'h0, DAC_MIDSCALE});
		// master code, then a transfer behind a repeated start
		i_m.start_cond();
		send({HS_CODE_TOP, 3'b111}, 1'b0);
		repeat (10) @(negedge clk_i);
		check("hs entry", {15'h0, hs_mode}, 16'h0001);
		i_m.start_cond();
		send({ADDR8_FIXED, strap_low, 1'b0}, 1'b1);
		send(8'h00, 1'b1);
		send(8'h5A, 1'b1);
		send(8'h33, 1'b0);
		check("hs kept", {15'h0, hs_mode}, 16'h0001);
		i_m.stop_cond();
		repeat (20) @(negedge clk_i);
		check("hs exit", {15'h0, hs_mode}, 16'h0000);
		check("hs write", {6'h0, dac_code}, 16'h005A);
		// five programming cycles; the fifth must leave memory alone
		therm = 4'h0;
		for (int i = 0; i < 5; i++) begin
			prog_code = 10'((i + 1) * 'h111);
			therm = {therm[2:0], 1'b1};
			dac_write({CMD_TOP_OTP, 3'b000, prog_code});
			check("program dac", {6'h0, dac_code}, {6'h0, prog_code});
			check("program count", {12'h0, otp_status}, {12'h0, therm});
		end
		acquire();
		check("stored acquire", {6'h0, dac_code}, 16'h0044);
		dac_read(16'hF044);
		dac_write(16'h03FF);
		gen_call(GC_RESET_CODE, 1'b1);
		check("gc stored", {6'h0, dac_code}, 16'h0044);
		check("gc count", {12'h0, otp_status}, 16'h000F);
		end_of_test();
	end
endmodule // tb
